/* hw/edu_regs.vh */
/*
 * Constants of the exception dispatch unit: vectors, push sizes, operand widths.
 * Assumes inclusion by the dispatch unit and its stack memory.
 */
`ifndef EDU_REGS_VH
`define EDU_REGS_VH
`define EDU_VEC_BREAK     8'h03
`define EDU_VEC_OVF       8'h04
`define EDU_VEC_RANGE     8'h05
`define EDU_VEC_FPU       8'h10
`define EDU_VEC_SIMD      8'h13
`define EDU_IVT_SHIFT     2
`define EDU_LEVEL_MAX     5'h1F
`define EDU_FP_CONDS      6
`define EDU_PUSH_LEGACY   4'h4
`define EDU_PUSH_WIDE     4'h8
`define EDU_NULL_SEL      16'h0000
`define EDU_MODE_REAL     2'h0
`define EDU_MODE_LEGACY   2'h1
`define EDU_MODE_WIDE     2'h2
`define EDU_SP_RESET      32'h0000_FFF0
`define EDU_MEM_AW        8
`endif

/* hw/edu_stack_mem.v */
/*
 * Small word memory holding stack contents and the real-mode vector table.
 * Assumes one clock; read data comes out of a register one cycle after the address.
 */
`timescale 1ns/100ps
`include "edu_regs.vh"
module edu_stack_mem (
    input  wire        i_core_clk,
    input  wire        i_we,
    input  wire [7:0]  i_waddr,
    input  wire [63:0] i_wdata,
    input  wire [7:0]  i_raddr,
    output reg  [63:0] o_rdata
);
    reg [63:0] mem [0:255];
    always @(posedge i_core_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
        o_rdata <= mem[i_raddr];
    end
endmodule

/* hw/edu_dispatch.v */
/*
 * Exception dispatch unit: trap instructions, real-mode vectoring, frame push,
 * floating-point error routing, 64-bit frame rules and frame create/release.
 * Assumes one-cycle command pulses from the decoder, issued only while o_busy is low.
 */
`timescale 1ns/100ps
`include "edu_regs.vh"
// How it works
// - Real mode: events do an implicit far call through the vector table.
// - Push flags, code segment, pointer and optional error code before handler entry.
// - Handler return happens only on the handler-return instruction.
// - Software trap calls the handler of its operand vector.
// - Overflow trap calls vector 4 only when overflow flag is set.
// - Arithmetic overflow alone never raises the overflow exception.
// - Breakpoint instruction always calls vector 3.
// - Range check raises vector 5 when operand is below i_range_lo or above i_range_hi.
// - No implicit bounds checks; only range check or software trap 5.
// - Six floating-point exception conditions are recognised.
// - Scalar floating-point exceptions, truncating store too, signal scalar error.
// - Packed floating-point exceptions signal the SIMD error instead.
// - In 64-bit mode table handlers run 64-bit, except management interrupt.
// - In 64-bit mode every push is an 8-byte zero-extended store.
// - Stack segment and pointer pushed always in 64-bit mode, in legacy mode on level change, never in real mode.
// - In 64-bit mode a level change loads a null stack segment.
// - Frame create decodes byte count and nesting level 0 to 31.
// - Nesting level is independent of privilege and I/O privilege.
// - Frame create builds and frame release discards a stack frame.
// - Scalar floating-point error uses vector 16, SIMD error vector 19.
// - Level zero: push frame base, copy stack pointer, subtract storage.
// - Nonzero level: copy display pointers by level, then push frame pointer.
module edu_dispatch (
    input  wire        i_core_clk,
    input  wire        i_rst_n,
    input  wire [1:0]  i_mode,
    input  wire        i_soft_trap,
    input  wire [7:0]  i_soft_vector,
    input  wire        i_ovf_trap,
    input  wire        i_brk,
    input  wire        i_range_chk,
    input  wire [31:0] i_range_val,
    input  wire [31:0] i_range_lo,
    input  wire [31:0] i_range_hi,
    input  wire        i_fp_scalar,
    input  wire        i_fp_packed,
    input  wire [5:0]  i_fp_conds,
    input  wire        i_sys_mgmt_irq,
    input  wire        i_ext_irq,
    input  wire [7:0]  i_ext_vector,
    input  wire        i_has_err,
    input  wire [31:0] i_err_code,
    input  wire        i_priv_change,
    input  wire        i_handler_ret,
    input  wire        i_frame_create,
    input  wire [15:0] i_frame_storage,
    input  wire [7:0]  i_frame_level,
    input  wire        i_frame_release,
    input  wire [31:0] i_flags_register,
    input  wire [15:0] i_code_seg,
    input  wire [31:0] i_instr_pointer,
    input  wire [15:0] i_stack_seg,
    input  wire        i_tbl_we,
    input  wire [7:0]  i_tbl_vector,
    input  wire [31:0] i_tbl_entry,
    output wire        o_busy,
    output reg         o_dispatch,
    output reg  [7:0]  o_vector,
    output reg  [15:0] o_new_cs,
    output reg  [31:0] o_new_ip,
    output reg         o_wide_code,
    output reg  [15:0] o_new_ss,
    output reg         o_returned,
    output reg  [31:0] o_ret_flags,
    output reg  [15:0] o_ret_cs,
    output reg  [31:0] o_ret_ip,
    output reg  [31:0] o_stack_ptr_reg,
    output reg  [31:0] o_frame_base_reg,
    output reg         o_frame_done,
    output reg  [5:0]  o_fp_latched
);
    // ------------------------------------------------------------------
    // State codes.
    // ------------------------------------------------------------------
    localparam ST_IDLE  = 8'h01;
    localparam ST_PUSH  = 8'h02;
    localparam ST_FETCH = 8'h04;
    localparam ST_LOAD  = 8'h08;
    localparam ST_POP   = 8'h10;
    localparam ST_COPY  = 8'h20;
    localparam ST_FPTR  = 8'h40;
    localparam ST_LEAVE = 8'h80;

    reg  [7:0]  state;
    reg  [7:0]  vec;
    reg  [2:0]  step;
    reg  [4:0]  level;
    reg  [4:0]  cnt;
    reg  [15:0] storage;
    reg  [31:0] frame_ptr;
    reg  [31:0] copy_ptr;
    reg         push_stack;
    reg         has_err;
    reg  [31:0] err_code;
    reg  [31:0] sv_flags;
    reg  [15:0] sv_cs;
    reg  [31:0] sv_ip;
    reg  [15:0] sv_ss;
    reg  [31:0] sv_sp;
    reg         mem_we;
    reg  [7:0]  mem_waddr;
    reg  [63:0] mem_wdata;
    reg  [7:0]  mem_raddr;
    wire [63:0] mem_rdata;
    reg         trig;
    reg  [7:0]  trig_vec;
    wire        wide;
    wire [3:0]  push_size;
    wire        out_of_range;

    // ------------------------------------------------------------------
    // Helpers.
    // ------------------------------------------------------------------
    function [7:0] word_of;
        input [31:0] addr;
        begin
            word_of = addr[10:3];
        end
    endfunction

    function [7:0] tbl_word;
        input [7:0] v;
        reg   [9:0] byte_addr;
        begin
            byte_addr = {2'b00, v} << `EDU_IVT_SHIFT;
            tbl_word = {1'b1, byte_addr[8:2]};
        end
    endfunction

    assign wide         = (i_mode == `EDU_MODE_WIDE);
    assign push_size    = wide ? `EDU_PUSH_WIDE : `EDU_PUSH_LEGACY;
    assign out_of_range = (i_range_val < i_range_lo) || (i_range_val > i_range_hi);
    assign o_busy       = (state != ST_IDLE);

    edu_stack_mem u_mem (
        .i_core_clk (i_core_clk),
        .i_we       (mem_we),
        .i_waddr    (mem_waddr),
        .i_wdata    (mem_wdata),
        .i_raddr    (mem_raddr),
        .o_rdata    (mem_rdata)
    );

    // ------------------------------------------------------------------
    // Event priority and vector selection.
    // ------------------------------------------------------------------
    always @* begin
        trig     = 1'b0;
        trig_vec = 8'h00;
        if (i_soft_trap) begin
            trig     = 1'b1;
            trig_vec = i_soft_vector;
        end else if (i_brk) begin
            trig     = 1'b1;
            trig_vec = `EDU_VEC_BREAK;
        end else if (i_ovf_trap && i_flags_register[11]) begin
            trig     = 1'b1;
            trig_vec = `EDU_VEC_OVF;
        end else if (i_range_chk && out_of_range) begin
            trig     = 1'b1;
            trig_vec = `EDU_VEC_RANGE;
        end else if (i_fp_packed && (i_fp_conds != 6'h00)) begin
            trig     = 1'b1;
            trig_vec = `EDU_VEC_SIMD;
        end else if (i_fp_scalar && (i_fp_conds != 6'h00)) begin
            trig     = 1'b1;
            trig_vec = `EDU_VEC_FPU;
        end else if (i_ext_irq) begin
            trig     = 1'b1;
            trig_vec = i_ext_vector;
        end
    end

    // ------------------------------------------------------------------
    // Sequencer.
    // ------------------------------------------------------------------
    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state            <= ST_IDLE;
            vec              <= 8'h00;
            step             <= 3'h0;
            level            <= 5'h00;
            cnt              <= 5'h00;
            storage          <= 16'h0000;
            frame_ptr        <= 32'h0000_0000;
            copy_ptr         <= 32'h0000_0000;
            push_stack       <= 1'b0;
            has_err          <= 1'b0;
            err_code         <= 32'h0000_0000;
            sv_flags         <= 32'h0000_0000;
            sv_cs            <= 16'h0000;
            sv_ip            <= 32'h0000_0000;
            sv_ss            <= 16'h0000;
            sv_sp            <= 32'h0000_0000;
            mem_we           <= 1'b0;
            mem_waddr        <= 8'h00;
            mem_wdata        <= 64'h0000_0000_0000_0000;
            mem_raddr        <= 8'h00;
            o_dispatch       <= 1'b0;
            o_vector         <= 8'h00;
            o_new_cs         <= 16'h0000;
            o_new_ip         <= 32'h0000_0000;
            o_wide_code      <= 1'b0;
            o_new_ss         <= 16'h0000;
            o_returned       <= 1'b0;
            o_ret_flags      <= 32'h0000_0000;
            o_ret_cs         <= 16'h0000;
            o_ret_ip         <= 32'h0000_0000;
            o_stack_ptr_reg  <= `EDU_SP_RESET;
            o_frame_base_reg <= 32'h0000_0000;
            o_frame_done     <= 1'b0;
            o_fp_latched     <= 6'h00;
        end else begin
            mem_we       <= 1'b0;
            o_dispatch   <= 1'b0;
            o_returned   <= 1'b0;
            o_frame_done <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (i_tbl_we) begin
                        mem_we    <= 1'b1;
                        mem_waddr <= tbl_word(i_tbl_vector);
                        mem_wdata <= {32'h0000_0000, i_tbl_entry};
                    end
                    if ((i_fp_scalar || i_fp_packed) && (i_fp_conds != 6'h00)) begin
                        o_fp_latched <= i_fp_conds[`EDU_FP_CONDS-1:0];
                    end
                    if (trig) begin
                        vec        <= trig_vec;
                        has_err    <= i_has_err;
                        err_code   <= i_err_code;
                        sv_flags   <= i_flags_register;
                        sv_cs      <= i_code_seg;
                        sv_ip      <= i_instr_pointer;
                        sv_ss      <= i_stack_seg;
                        sv_sp      <= o_stack_ptr_reg;
                        push_stack <= wide || ((i_mode == `EDU_MODE_LEGACY) && i_priv_change);
                        o_new_ss   <= (wide && i_priv_change) ? `EDU_NULL_SEL : i_stack_seg;
                        step       <= 3'h0;
                        state      <= ST_PUSH;
                    end else if (i_handler_ret) begin
                        mem_raddr <= word_of(o_stack_ptr_reg);
                        step      <= 3'h0;
                        state     <= ST_POP;
                    end else if (i_frame_create) begin
                        level     <= i_frame_level[4:0] & `EDU_LEVEL_MAX;
                        storage   <= i_frame_storage;
                        cnt       <= 5'h00;
                        mem_we    <= 1'b1;
                        mem_waddr <= word_of(o_stack_ptr_reg - {28'h0, push_size});
                        mem_wdata <= {32'h0000_0000, o_frame_base_reg};
                        frame_ptr <= o_stack_ptr_reg - {28'h0, push_size};
                        copy_ptr  <= o_frame_base_reg;
                        o_stack_ptr_reg <= o_stack_ptr_reg - {28'h0, push_size};
                        state     <= (i_frame_level[4:0] == 5'h00) ? ST_FPTR : ST_COPY;
                    end else if (i_frame_release) begin
                        mem_raddr       <= word_of(o_frame_base_reg);
                        step            <= 3'h0;
                        o_stack_ptr_reg <= o_frame_base_reg;
                        state           <= ST_LEAVE;
                    end
                end
                ST_PUSH: begin
                    // Zero-extended pushes, one word per cycle; without a stack push, step 0 writes nothing and skips to the flags.
                    mem_we    <= 1'b1;
                    mem_waddr <= word_of(o_stack_ptr_reg - {28'h0, push_size});
                    o_stack_ptr_reg <= o_stack_ptr_reg - {28'h0, push_size};
                    step      <= step + 3'h1;
                    case (step)
                        3'h0: mem_wdata <= {48'h0, sv_ss};
                        3'h1: mem_wdata <= {32'h0, sv_sp};
                        3'h2: mem_wdata <= {32'h0, sv_flags};
                        3'h3: mem_wdata <= {48'h0, sv_cs};
                        3'h4: mem_wdata <= {32'h0, sv_ip};
                        default: mem_wdata <= {32'h0, err_code};
                    endcase
                    if (!push_stack && step == 3'h0) begin
                        mem_we          <= 1'b0;
                        o_stack_ptr_reg <= o_stack_ptr_reg;
                        step            <= 3'h2;
                    end else if (step == 3'h4 && !has_err) begin
                        mem_raddr <= tbl_word(vec);
                        state     <= ST_FETCH;
                    end else if (step == 3'h5) begin
                        mem_raddr <= tbl_word(vec);
                        state     <= ST_FETCH;
                    end
                end
                ST_FETCH: begin
                    state <= ST_LOAD;
                end
                ST_LOAD: begin
                    o_new_ip    <= {16'h0000, mem_rdata[15:0]};
                    o_new_cs    <= mem_rdata[31:16];
                    o_vector    <= vec;
                    o_wide_code <= wide && !i_sys_mgmt_irq;
                    o_dispatch  <= 1'b1;
                    state       <= ST_IDLE;
                end
                ST_POP: begin
                    step <= step + 3'h1;
                    case (step)
                        3'h0: mem_raddr <= word_of(o_stack_ptr_reg + {28'h0, push_size});
                        3'h1: begin
                            o_ret_ip  <= mem_rdata[31:0];
                            mem_raddr <= word_of(o_stack_ptr_reg + {27'h0, push_size, 1'b0});
                        end
                        3'h2: o_ret_cs <= mem_rdata[15:0];
                        3'h3: begin
                            o_ret_flags     <= mem_rdata[31:0];
                            o_stack_ptr_reg <= o_stack_ptr_reg + {26'h0, push_size, 2'b00} -
                                               {28'h0, push_size};
                            o_returned      <= 1'b1;
                            state           <= ST_IDLE;
                        end
                        default: state <= ST_IDLE;
                    endcase
                end
                ST_COPY: begin
                    if (cnt + 5'h01 >= level) begin
                        state <= ST_FPTR;
                    end else begin
                        copy_ptr  <= copy_ptr - 32'h4;
                        mem_we    <= 1'b1;
                        mem_waddr <= word_of(o_stack_ptr_reg - {28'h0, push_size});
                        mem_wdata <= {32'h0, copy_ptr - 32'h4};
                        o_stack_ptr_reg <= o_stack_ptr_reg - {28'h0, push_size};
                        cnt       <= cnt + 5'h01;
                    end
                end
                ST_FPTR: begin
                    if (level != 5'h00) begin
                        mem_we    <= 1'b1;
                        mem_waddr <= word_of(o_stack_ptr_reg - {28'h0, push_size});
                        mem_wdata <= {32'h0, frame_ptr};
                        o_stack_ptr_reg <= o_stack_ptr_reg - {28'h0, push_size} - {16'h0, storage};
                    end else begin
                        o_stack_ptr_reg <= o_stack_ptr_reg - {16'h0, storage};
                    end
                    o_frame_base_reg <= frame_ptr;
                    o_frame_done     <= 1'b1;
                    state            <= ST_IDLE;
                end
                ST_LEAVE: begin
                    step <= step + 3'h1;
                    if (step == 3'h1) begin
                        o_frame_base_reg <= mem_rdata[31:0];
                        o_stack_ptr_reg  <= o_stack_ptr_reg + {28'h0, push_size};
                        o_frame_done     <= 1'b1;
                        step             <= 3'h0;
                        state            <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end
endmodule

/* sim/edu_dispatch_checker.sv */
/*
 * Port checker of the exception dispatch unit.
 * Assumes mode, privilege change and management interrupt inputs stay steady through an event.
 */
`timescale 1ns/100ps
`include "edu_regs.vh"
module edu_dispatch_checker (
    input wire        i_core_clk,
    input wire        i_rst_n,
    input wire [1:0]  i_mode,
    input wire        i_soft_trap,
    input wire        i_ovf_trap,
    input wire        i_brk,
    input wire        i_range_chk,
    input wire [31:0] i_range_val,
    input wire [31:0] i_range_lo,
    input wire [31:0] i_range_hi,
    input wire        i_fp_scalar,
    input wire        i_fp_packed,
    input wire [5:0]  i_fp_conds,
    input wire        i_sys_mgmt_irq,
    input wire        i_ext_irq,
    input wire        i_priv_change,
    input wire        i_handler_ret,
    input wire        i_frame_create,
    input wire [7:0]  i_frame_level,
    input wire        i_frame_release,
    input wire [31:0] i_flags_register,
    input wire        i_tbl_we,
    input wire        o_busy,
    input wire        o_dispatch,
    input wire [7:0]  o_vector,
    input wire        o_wide_code,
    input wire [15:0] o_new_ss,
    input wire        o_returned,
    input wire        o_frame_done
);
// ----------------------------------------
// Request priority helpers.
// ----------------------------------------
wire w_brk = !o_busy && !i_soft_trap;
wire w_ovf = w_brk && !i_brk;
wire w_rng = w_ovf && !i_ovf_trap;
wire w_pk  = w_rng && !i_range_chk;
wire w_sc  = w_pk && !i_fp_packed;
wire w_ret = w_sc && !i_fp_scalar && !i_ext_irq;
wire w_cr  = w_ret && !i_handler_ret;
wire w_rel = w_cr && !i_frame_create;
wire q_fp  = !i_fp_packed && !i_fp_scalar && !i_ext_irq && !i_handler_ret && !i_frame_create && !i_frame_release
             && !i_tbl_we;
wire r_out = (i_range_val < i_range_lo) || (i_range_val > i_range_hi);
// ----------------------------------------
// Assertions.
// ----------------------------------------
default clocking cb @(posedge i_core_clk); endclocking
default disable iff (!i_rst_n);
brk_vector_a: assert property (w_brk && i_brk |-> ##[3:12] (o_dispatch && o_vector == `EDU_VEC_BREAK))
    else $error("breakpoint not dispatched to its vector");
ovf_taken_a: assert property (w_ovf && i_ovf_trap && i_flags_register[11]
    |-> ##[3:12] (o_dispatch && o_vector == `EDU_VEC_OVF))
    else $error("overflow trap with flag set not dispatched");
ovf_ignored_a: assert property (w_ovf && i_ovf_trap && !i_flags_register[11] && !i_range_chk && q_fp |=> !o_busy)
    else $error("overflow trap with flag clear was taken");
range_out_a: assert property (w_rng && i_range_chk && r_out
    |-> ##[3:12] (o_dispatch && o_vector == `EDU_VEC_RANGE))
    else $error("range violation not dispatched");
range_in_a: assert property (w_rng && i_range_chk && !r_out && q_fp |=> !o_busy)
    else $error("range check in bounds was taken");
packed_vec_a: assert property (w_pk && i_fp_packed && |i_fp_conds
    |-> ##[3:12] (o_dispatch && o_vector == `EDU_VEC_SIMD))
    else $error("packed error not on its vector");
scalar_vec_a: assert property (w_sc && i_fp_scalar && |i_fp_conds
    |-> ##[3:12] (o_dispatch && o_vector == `EDU_VEC_FPU))
    else $error("scalar error not on its vector");
wide_code_a: assert property (o_dispatch && i_mode == `EDU_MODE_WIDE |-> o_wide_code == !i_sys_mgmt_irq)
    else $error("wide code flag wrong");
null_ss_a: assert property (o_dispatch && i_mode == `EDU_MODE_WIDE && i_priv_change |-> o_new_ss == `EDU_NULL_SEL)
    else $error("stack segment not null");
ret_delay_a: assert property (w_ret && i_handler_ret |-> ##5 o_returned)
    else $error("return not completed in time");
ret_cause_a: assert property ($rose(o_returned) |-> $past(i_handler_ret, 5))
    else $error("return without return request");
create_zero_a: assert property (w_cr && i_frame_create && i_frame_level[4:0] == 5'h00 |-> ##2 o_frame_done)
    else $error("level zero frame not done in time");
release_a: assert property (w_rel && i_frame_release |-> ##3 o_frame_done)
    else $error("frame release not done in time");
cover property (o_dispatch && o_wide_code);
cover property (o_returned);
cover property (o_frame_done);
cover property (w_ovf && i_ovf_trap && !i_flags_register[11]);
endmodule
bind edu_dispatch edu_dispatch_checker chk (.*);

/* sim/exception_dispatch_unit_tb.sv */
/*
 * Self-checking bench of the exception dispatch unit.
 * Assumes the dispatch unit and its stack memory are compiled alongside.
 */
`timescale 1ns/100ps
`include "edu_regs.vh"
module exception_dispatch_unit_tb;
reg         i_core_clk = 0, i_rst_n = 0, i_soft_trap = 0, i_ovf_trap = 0, i_brk = 0, i_range_chk = 0;
reg         i_fp_scalar = 0, i_fp_packed = 0, i_sys_mgmt_irq = 0, i_ext_irq = 0, i_has_err = 0;
reg         i_priv_change = 0, i_handler_ret = 0, i_frame_create = 0, i_frame_release = 0, i_tbl_we = 0;
reg  [1:0]  i_mode = 0;
reg  [5:0]  i_fp_conds = 0;
reg  [7:0]  i_soft_vector = 0, i_ext_vector = 0, i_frame_level = 0, i_tbl_vector = 0;
reg  [15:0] i_frame_storage = 0, i_code_seg = 16'h1234, i_stack_seg = 16'h0ABC;
reg  [31:0] i_range_val = 0, i_range_lo = 0, i_range_hi = 0, i_err_code = 0, i_flags_register = 0;
reg  [31:0] i_instr_pointer = 0, i_tbl_entry = 0;
wire        o_busy, o_dispatch, o_wide_code, o_returned, o_frame_done;
wire [7:0]  o_vector;
wire [5:0]  o_fp_latched;
wire [15:0] o_new_cs, o_new_ss, o_ret_cs;
wire [31:0] o_new_ip, o_ret_flags, o_ret_ip, o_stack_ptr_reg, o_frame_base_reg;
integer     fails = 0, num_checks = 0, i, k;
reg  [31:0] sp_m, s;
reg  [7:0]  v;
edu_dispatch dut (.*);
initial forever #20 i_core_clk = ~i_core_clk;
// ----------------------------------------
// Helpers.
// ----------------------------------------
function [31:0] ent(input [7:0] x);
    ent = {8'hC0, x, x ^ 8'h3C, 8'h21};
endfunction
task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
        fails++;
        $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
    end
endtask
task conclude;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
endtask
task rst;
    @(negedge i_core_clk);
    i_rst_n = 0;
    repeat (20) @(negedge i_core_clk);
    i_rst_n = 1;
    sp_m = 32'h0000FFF0;
endtask
// Order: soft, ovf, brk, range, scalar, packed, ext, ret, create, release, table write.
task pulse(input [10:0] m);
    @(negedge i_core_clk);
    {i_soft_trap, i_ovf_trap, i_brk, i_range_chk, i_fp_scalar, i_fp_packed, i_ext_irq, i_handler_ret,
     i_frame_create, i_frame_release, i_tbl_we} = m;
    @(negedge i_core_clk);
    {i_soft_trap, i_ovf_trap, i_brk, i_range_chk, i_fp_scalar, i_fp_packed, i_ext_irq, i_handler_ret,
     i_frame_create, i_frame_release, i_tbl_we} = 11'h000;
endtask
task load(input [7:0] x);
    i_tbl_vector = x;
    i_tbl_entry = ent(x);
    pulse(11'h001);
endtask
task automatic disp(input [10:0] m, input [7:0] x, input integer n, input integer sz);
    pulse(m);
    for (k = 0; k < 20 && o_dispatch !== 1'b1; k++) begin
        @(posedge i_core_clk);
        #1;
    end
    chk(o_dispatch, 1, "dispatch pulse");
    chk(o_vector, x, "vector");
    if (i_mode == `EDU_MODE_REAL) begin
        chk(o_new_cs, ent(x) >> 16, "handler segment");
        chk(o_new_ip, ent(x) & 32'h0000FFFF, "handler pointer");
    end
    sp_m = sp_m - n * sz;
    @(negedge i_core_clk);
    chk(o_stack_ptr_reg, sp_m, "stack pointer");
    repeat (2) @(negedge i_core_clk);
endtask
task nodisp(input [10:0] m);
    pulse(m);
    chk(o_busy, 0, "refused busy");
    repeat (10) @(negedge i_core_clk);
    chk(o_stack_ptr_reg, sp_m, "refused stack");
endtask
task frame(input [10:0] m, input [7:0] lv, input integer nc, input [31:0] fb, input [31:0] sp);
    i_frame_level = lv;
    pulse(m);
    for (k = 1; k < 60 && o_frame_done !== 1'b1; k++) begin
        @(posedge i_core_clk);
        #1;
    end
    chk(k, nc, "frame cycles");
    chk(o_frame_base_reg, fb, "frame base");
    chk(o_stack_ptr_reg, sp, "frame stack");
    repeat (2) @(negedge i_core_clk);
endtask
// ----------------------------------------
// Tests.
// ----------------------------------------
initial begin
    repeat (20000) @(posedge i_core_clk);
    fails++;
    $display("unexpected at %0t: watchdog", $time);
    conclude();
end
initial begin
    void'($urandom(69));
    rst();
    chk(o_stack_ptr_reg, 32'h0000FFF0, "reset stack");
    chk({o_busy, o_dispatch, o_returned, o_frame_done}, 0, "reset flags");
    $display("reset test done");
    i_flags_register = $urandom | 32'h0000_0800;
    i_instr_pointer = $urandom;
    for (i = 0; i < 5; i++) load(i < 3 ? 8'h03 + i[7:0] : i == 3 ? 8'h10 : 8'h13);
    disp(11'h100, 8'h03, 3, 4);
    disp(11'h200, 8'h04, 3, 4);
    i_flags_register[11] = 0;
    nodisp(11'h200);
    i_soft_vector = 8'h04;
    disp(11'h400, 8'h04, 3, 4);
    i_range_lo = $urandom % 1000 + 1;
    i_range_hi = i_range_lo + 50;
    for (i = 0; i < 4; i++) begin
        i_range_val = i == 0 ? i_range_lo - 1 : i == 1 ? i_range_hi + 1 : i == 2 ? i_range_lo : i_range_hi;
        if (i < 2) disp(11'h080, 8'h05, 3, 4);
        else nodisp(11'h080);
    end
    i_soft_vector = 8'h05;
    disp(11'h400, 8'h05, 3, 4);
    for (i = 0; i < 6; i++) begin
        i_fp_conds = 6'h01 << i;
        if (i[0]) disp(11'h020, 8'h13, 3, 4);
        else disp(11'h040, 8'h10, 3, 4);
        chk(o_fp_latched, i_fp_conds, "fp conditions");
    end
    i_fp_conds = 0;
    nodisp(11'h060);
    for (i = 0; i < 4; i++) begin
        v = 8'h20 + $urandom % 64;
        load(v);
        i_soft_vector = v;
        i_ext_vector = v;
        disp(i[0] ? 11'h010 : 11'h400, v, 3, 4);
    end
    i_has_err = 1;
    i_err_code = $urandom;
    disp(11'h100, 8'h03, 4, 4);
    i_has_err = 0;
    $display("real mode test done");
    i_mode = `EDU_MODE_LEGACY;
    disp(11'h100, 8'h03, 3, 4);
    i_priv_change = 1;
    disp(11'h100, 8'h03, 5, 4);
    chk(o_new_ss, i_stack_seg, "legacy segment");
    i_mode = `EDU_MODE_WIDE;
    i_sys_mgmt_irq = 1;
    disp(11'h100, 8'h03, 5, 8);
    chk(o_wide_code, 0, "management code");
    i_sys_mgmt_irq = 0;
    i_priv_change = 0;
    disp(11'h100, 8'h03, 5, 8);
    chk(o_wide_code, 1, "wide code");
    pulse(11'h008);
    for (k = 0; k < 20 && o_returned !== 1'b1; k++) begin
        @(posedge i_core_clk);
        #1;
    end
    chk(o_returned, 1, "return pulse");
    chk(o_ret_flags, i_flags_register, "return flags");
    chk(o_ret_cs, i_code_seg, "return segment");
    chk(o_ret_ip, i_instr_pointer, "return pointer");
    $display("wide mode test done");
    rst();
    i_mode = `EDU_MODE_REAL;
    s = $urandom % 256;
    i_frame_storage = s[15:0];
    frame(11'h004, 8'hE0, 2, 32'h0000FFEC, 32'h0000FFEC - s);
    frame(11'h002, 8'h00, 3, 32'h0, 32'h0000FFF0);
    i_priv_change = 1;
    frame(11'h004, 8'h63, 5, 32'h0000FFEC, 32'h0000FFEC - 12 - s);
    $display("frame test done");
    conclude();
end
endmodule
